// >>> hw/dcmd_sync.sv
// Two-flop synchroniser for levels and toggles, any width.
// Assumes each bit is a level or toggle that changes slowly vs the clock.
`timescale 1ns/1ps
`default_nettype none

module dcmd_sync #(
    parameter int WIDTH = 1
) (
    // Destination clock
    input wire logic clk_i,
    // Asynchronous source and synchronised result
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_ff; // First stage, read only by the second
    logic [WIDTH-1:0] sync_ff; // Second stage

    // Plain two-stage capture, no reset needed
    always_ff @(posedge clk_i)
    begin
        meta_ff <= async_i;
        sync_ff <= meta_ff;
    end

    assign sync_o = sync_ff;

endmodule

`default_nettype wire

// >>> hw/dcmd_top.sv
// Command decoder with calibration pattern readout for a DDR3-style device.
// Assumes command pins are synchronous to ck_i; system side runs on clk_i.
// How it works
// - Third register bit 2 redirects reads to pattern
// - Bit clear means array reads, location ignored
// - Pattern reads are one bit replicated wide
// - Narrow organisation: pin 0 carries, others repeat
// - Wide organisation: both lane bit 0 carry
// - Eight-beat pattern read returns beats 0..7
// - Chopped read picks nibble by column bit 2
// - Beat 0 is lsb, beat 7 msb
// - Location zero alternates 0,1; others reserved
// - Bit 12 chops on the fly when enabled
// - Bank and other column bits ignored then
// - Pattern reads use normal read latency
// - Write decoded from strobes with both clock enables
// - Read decoded from strobes with both clock enables
// - Bit 10 high requests auto-precharge
// - On-the-fly bit 12 low chops, high full
// - Auto-precharge read acts as plain read then
// - Third register written with bank code 011
`timescale 1ns/1ps
`default_nettype none

module dcmd_top
    import dcmd_pkg::*;
(
    // System clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // Link clock and command pins
    input wire logic ck_i,
    input wire logic cke_i,
    input wire logic cs_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    input wire logic [2:0] ba_i,
    input wire logic [15:0] addr_i,
    // Array read data from link-side array logic
    input wire logic [15:0] arr_rdata_i,
    // Data pins, output side
    output logic [15:0] dq_o,
    output logic dq_oe_n_o,
    // Decoded command report, system domain
    output logic cmd_valid_o,
    output dcmd_kind_e cmd_kind_o,
    output logic [2:0] cmd_bank_o,
    output logic [15:0] cmd_addr_o,
    output logic cmd_ap_o,
    output logic cmd_chop_o,
    // Status, system domain
    output logic mpr_en_o,
    output dcmd_pwr_e pwr_state_o
);

    // Link-side reset taken from the system reset
    logic lrst;
    dcmd_sync #(.WIDTH(1)) u_rst_sync (
        .clk_i(ck_i),
        .async_i(sys_rst_i),
        .sync_o(lrst)
    );

    // Link-side state
    logic cke_prev_ff, nxt_cke_prev; // Clock enable seen at the last edge
    logic [15:0] base_mr_ff, nxt_base_mr; // Base mode register
    logic [2:0] third_mr_ff, nxt_third_mr; // Third mode register low bits
    dcmd_pwr_e pwr_ff, nxt_pwr; // Power state
    logic tgl_ff, nxt_tgl; // Event toggle toward system side
    dcmd_kind_e ev_kind_ff, nxt_ev_kind; // Held event fields
    logic [2:0] ev_bank_ff, nxt_ev_bank;
    logic [15:0] ev_addr_ff, nxt_ev_addr;
    logic ev_ap_ff, nxt_ev_ap;
    logic ev_chop_ff, nxt_ev_chop;

    // Decode helpers
    dcmd_kind_e dec_kind; // Command at this edge
    logic mpr_on; // Pattern mode active
    logic chop; // Four-beat burst selected
    logic otf; // On-the-fly burst length enabled

    assign mpr_on = third_mr_ff[`DCMD_MPR_EN_BIT];
    assign otf = (base_mr_ff[`DCMD_BL_LSB +: 2] == `DCMD_BL_OTF);

    // Burst chop choice per command
    always_comb
    begin
        if (otf)
        begin
            chop = ~addr_i[`DCMD_A_BC];
        end
        else
        begin
            chop = (base_mr_ff[`DCMD_BL_LSB +: 2] == `DCMD_BL_FIXED4);
        end
    end

    // Command truth table decode
    always_comb
    begin
        dec_kind = DCMD_NONE;
        if (cke_prev_ff && cke_i && !cs_n_i)
        begin
            unique case ({ras_n_i, cas_n_i, we_n_i})
                3'h0: dec_kind = DCMD_MRS;
                3'h1: dec_kind = DCMD_REF;
                3'h2: dec_kind = addr_i[`DCMD_A_AP] ? DCMD_PREA : DCMD_PRE;
                3'h3: dec_kind = DCMD_ACT;
                3'h4: dec_kind = DCMD_WR;
                3'h5: dec_kind = DCMD_RD;
                3'h6: dec_kind = addr_i[`DCMD_A_AP] ? DCMD_ZQCL : DCMD_ZQCS;
                3'h7: dec_kind = DCMD_NONE;
            endcase
        end
        else if (cke_prev_ff && !cke_i)
        begin
            // Entry on the falling clock enable
            if (!cs_n_i && {ras_n_i, cas_n_i, we_n_i} == 3'h1)
            begin
                dec_kind = DCMD_SRE;
            end
            else if (cs_n_i || {ras_n_i, cas_n_i, we_n_i} == 3'h7)
            begin
                dec_kind = DCMD_PDE;
            end
        end
        else if (!cke_prev_ff && cke_i && pwr_ff != DCMD_PWR_ACTIVE)
        begin
            // Exit on the rising clock enable
            if (cs_n_i || {ras_n_i, cas_n_i, we_n_i} == 3'h7)
            begin
                dec_kind = (pwr_ff == DCMD_PWR_SELFREF) ? DCMD_SRX : DCMD_PDX;
            end
        end
    end

    // Mode registers, power state and event capture: next values
    always_comb
    begin
        nxt_cke_prev = cke_i;
        nxt_base_mr = base_mr_ff;
        nxt_third_mr = third_mr_ff;
        nxt_pwr = pwr_ff;
        nxt_tgl = tgl_ff;
        nxt_ev_kind = ev_kind_ff;
        nxt_ev_bank = ev_bank_ff;
        nxt_ev_addr = ev_addr_ff;
        nxt_ev_ap = ev_ap_ff;
        nxt_ev_chop = ev_chop_ff;
        if (dec_kind == DCMD_MRS)
        begin
            if (ba_i == `DCMD_MR_BASE_BA)
            begin
                nxt_base_mr = addr_i;
            end
            else if (ba_i == `DCMD_MR_THIRD_BA)
            begin
                nxt_third_mr = addr_i[2:0];
            end
        end
        unique case (dec_kind)
            DCMD_SRE: nxt_pwr = DCMD_PWR_SELFREF;
            DCMD_PDE: nxt_pwr = DCMD_PWR_DOWN;
            DCMD_SRX, DCMD_PDX: nxt_pwr = DCMD_PWR_ACTIVE;
            default: nxt_pwr = pwr_ff;
        endcase
        // Report everything but no-ops; in pattern mode only reads and mode sets
        if (dec_kind != DCMD_NONE &&
            (!mpr_on || dec_kind == DCMD_RD || dec_kind == DCMD_MRS))
        begin
            nxt_tgl = ~tgl_ff;
            nxt_ev_kind = dec_kind;
            nxt_ev_bank = ba_i;
            nxt_ev_addr = addr_i;
            nxt_ev_ap = addr_i[`DCMD_A_AP] && !mpr_on;
            nxt_ev_chop = chop;
        end
    end

    // Mode registers, power state and event capture: registers
    always_ff @(posedge ck_i)
    begin
        if (lrst)
        begin
            cke_prev_ff <= 1'b0;
            base_mr_ff <= `DCMD_BASE_MR_RST;
            third_mr_ff <= `DCMD_THIRD_MR_RST;
            pwr_ff <= DCMD_PWR_ACTIVE;
            tgl_ff <= 1'b0;
            ev_kind_ff <= DCMD_NONE;
            ev_bank_ff <= 3'h0;
            ev_addr_ff <= 16'h0000;
            ev_ap_ff <= 1'b0;
            ev_chop_ff <= 1'b0;
        end
        else
        begin
            cke_prev_ff <= nxt_cke_prev;
            base_mr_ff <= nxt_base_mr;
            third_mr_ff <= nxt_third_mr;
            pwr_ff <= nxt_pwr;
            tgl_ff <= nxt_tgl;
            ev_kind_ff <= nxt_ev_kind;
            ev_bank_ff <= nxt_ev_bank;
            ev_addr_ff <= nxt_ev_addr;
            ev_ap_ff <= nxt_ev_ap;
            ev_chop_ff <= nxt_ev_chop;
        end
    end

    // Read burst engine state
    dcmd_burst_e bst_ff, nxt_bst; // Engine state
    logic [3:0] lat_ff, nxt_lat; // Latency countdown
    logic [3:0] left_ff, nxt_left; // Beats still to send
    logic [2:0] beat_ff, nxt_beat; // Burst-order beat index
    logic src_mpr_ff, nxt_src_mpr; // Burst sourced from pattern
    logic [7:0] pat_ff, nxt_pat; // Selected pattern location
    logic [15:0] dq_ff, nxt_dq; // Registered data pins
    logic oe_n_ff, nxt_oe_n; // Registered output enable, low drives

    // Burst engine: next values
    always_comb
    begin
        nxt_bst = bst_ff;
        nxt_lat = lat_ff;
        nxt_left = left_ff;
        nxt_beat = beat_ff;
        nxt_src_mpr = src_mpr_ff;
        nxt_pat = pat_ff;
        nxt_dq = dq_ff;
        nxt_oe_n = 1'b1;
        unique case (bst_ff)
            DCMD_BURST_IDLE:
            begin
                nxt_dq = 16'h0000;
            end
            DCMD_BURST_WAIT:
            begin
                nxt_lat = lat_ff - 4'h1;
                if (lat_ff == 4'h1)
                begin
                    nxt_bst = DCMD_BURST_DATA;
                end
            end
            DCMD_BURST_DATA:
            begin
                nxt_oe_n = 1'b0;
                if (src_mpr_ff)
                begin
                    nxt_dq = {16{pat_ff[beat_ff]}};
                end
                else
                begin
                    nxt_dq = arr_rdata_i;
                end
                nxt_beat = beat_ff + 3'h1;
                nxt_left = left_ff - 4'h1;
                if (left_ff == 4'h1)
                begin
                    nxt_bst = DCMD_BURST_IDLE;
                end
            end
        endcase
        // A new read restarts the engine; every other command leaves it running
        if (dec_kind == DCMD_RD)
        begin
            nxt_bst = DCMD_BURST_WAIT;
            nxt_lat = `DCMD_READ_LATENCY;
            nxt_src_mpr = mpr_on;
            nxt_left = chop ? `DCMD_BEATS_BC4 : `DCMD_BEATS_BL8;
            // Only column bit 2 steers order; bank and other bits unused
            nxt_beat = (chop && addr_i[`DCMD_A_NIBBLE]) ? `DCMD_UPPER_NIBBLE : 3'h0;
            if (third_mr_ff[`DCMD_LOC_LSB +: 2] == `DCMD_LOC_PREDEF)
            begin
                nxt_pat = `DCMD_PATTERN_LOC0;
            end
            else
            begin
                nxt_pat = `DCMD_RESERVED_VALUE;
            end
        end
    end

    // Burst engine: registers
    always_ff @(posedge ck_i)
    begin
        if (lrst)
        begin
            bst_ff <= DCMD_BURST_IDLE;
            lat_ff <= 4'h0;
            left_ff <= 4'h0;
            beat_ff <= 3'h0;
            src_mpr_ff <= 1'b0;
            pat_ff <= 8'h00;
            dq_ff <= 16'h0000;
            oe_n_ff <= 1'b1;
        end
        else
        begin
            bst_ff <= nxt_bst;
            lat_ff <= nxt_lat;
            left_ff <= nxt_left;
            beat_ff <= nxt_beat;
            src_mpr_ff <= nxt_src_mpr;
            pat_ff <= nxt_pat;
            dq_ff <= nxt_dq;
            oe_n_ff <= nxt_oe_n;
        end
    end

    assign dq_o = dq_ff;
    assign dq_oe_n_o = oe_n_ff;

    // Crossing into the system domain: toggle plus two status levels
    logic [3:0] xs; // Synchronised toggle, mode bit, power state
    dcmd_sync #(.WIDTH(4)) u_evt_sync (
        .clk_i(clk_i),
        .async_i({tgl_ff, mpr_on, pwr_ff}),
        .sync_o(xs)
    );

    // System-side report registers
    logic tgl_seen_ff, nxt_tgl_seen; // Last toggle level seen
    logic valid_ff, nxt_valid; // One-cycle report pulse
    dcmd_kind_e kind_ff, nxt_kind;
    logic [2:0] bank_ff, nxt_bank;
    logic [15:0] addr_ff, nxt_addr;
    logic ap_ff, nxt_ap;
    logic chop_ff, nxt_chop;
    logic mpr_ff, nxt_mpr;
    dcmd_pwr_e pwr_s_ff, nxt_pwr_s;

    // System side: next values, fields are stable when the toggle lands
    always_comb
    begin
        nxt_tgl_seen = xs[3];
        nxt_valid = xs[3] ^ tgl_seen_ff;
        nxt_kind = kind_ff;
        nxt_bank = bank_ff;
        nxt_addr = addr_ff;
        nxt_ap = ap_ff;
        nxt_chop = chop_ff;
        nxt_mpr = xs[2];
        nxt_pwr_s = dcmd_pwr_e'(xs[1:0]);
        if (xs[3] ^ tgl_seen_ff)
        begin
            nxt_kind = ev_kind_ff;
            nxt_bank = ev_bank_ff;
            nxt_addr = ev_addr_ff;
            nxt_ap = ev_ap_ff;
            nxt_chop = ev_chop_ff;
        end
    end

    // System side: registers
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            tgl_seen_ff <= 1'b0;
            valid_ff <= 1'b0;
            kind_ff <= DCMD_NONE;
            bank_ff <= 3'h0;
            addr_ff <= 16'h0000;
            ap_ff <= 1'b0;
            chop_ff <= 1'b0;
            mpr_ff <= 1'b0;
            pwr_s_ff <= DCMD_PWR_ACTIVE;
        end
        else
        begin
            tgl_seen_ff <= nxt_tgl_seen;
            valid_ff <= nxt_valid;
            kind_ff <= nxt_kind;
            bank_ff <= nxt_bank;
            addr_ff <= nxt_addr;
            ap_ff <= nxt_ap;
            chop_ff <= nxt_chop;
            mpr_ff <= nxt_mpr;
            pwr_s_ff <= nxt_pwr_s;
        end
    end

    assign cmd_valid_o = valid_ff;
    assign cmd_kind_o = kind_ff;
    assign cmd_bank_o = bank_ff;
    assign cmd_addr_o = addr_ff;
    assign cmd_ap_o = ap_ff;
    assign cmd_chop_o = chop_ff;
    assign mpr_en_o = mpr_ff;
    assign pwr_state_o = pwr_s_ff;

endmodule

`default_nettype wire

// >>> shared/dcmd_map.svh
// Constants for the command decoder and calibration pattern readout.
// Assumes inclusion by the package and the design files by bare name.
`ifndef DCMD_MAP_SVH
`define DCMD_MAP_SVH

// Mode register select codes on the bank address pins
`define DCMD_MR_BASE_BA 3'h0
`define DCMD_MR_THIRD_BA 3'h3

// Field positions inside the opcode
`define DCMD_BL_LSB 0
`define DCMD_MPR_EN_BIT 2
`define DCMD_LOC_LSB 0
`define DCMD_A_AP 10
`define DCMD_A_BC 12
`define DCMD_A_NIBBLE 2

// Burst length field codes in the base mode register
`define DCMD_BL_FIXED8 2'h0
`define DCMD_BL_OTF 2'h1
`define DCMD_BL_FIXED4 2'h2

// Reset values of the stored mode registers
`define DCMD_BASE_MR_RST 16'h0000
`define DCMD_THIRD_MR_RST 3'h0

// Calibration pattern contents, beat 0 in the lsb
`define DCMD_PATTERN_LOC0 8'haa
`define DCMD_RESERVED_VALUE 8'h00
`define DCMD_LOC_PREDEF 2'h0

// Burst geometry and read latency in link clock cycles
`define DCMD_BEATS_BL8 4'h8
`define DCMD_BEATS_BC4 4'h4
`define DCMD_UPPER_NIBBLE 3'h4
`define DCMD_READ_LATENCY 4'h5

`endif

// >>> shared/dcmd_pkg.sv
// Types shared by the command decoder design files.
// Assumes the constants header sits beside it.
`include "dcmd_map.svh"

package dcmd_pkg;

    // Decoded command kinds reported to the system side
    typedef enum logic [3:0] {
        DCMD_NONE, DCMD_MRS, DCMD_REF, DCMD_PRE, DCMD_PREA, DCMD_ACT,
        DCMD_WR, DCMD_RD, DCMD_ZQCL, DCMD_ZQCS, DCMD_SRE, DCMD_SRX,
        DCMD_PDE, DCMD_PDX
    } dcmd_kind_e;

    // Power state of the link side
    typedef enum logic [1:0] {
        DCMD_PWR_ACTIVE, DCMD_PWR_DOWN, DCMD_PWR_SELFREF
    } dcmd_pwr_e;

    // Read burst engine states
    typedef enum logic [1:0] {
        DCMD_BURST_IDLE, DCMD_BURST_WAIT, DCMD_BURST_DATA
    } dcmd_burst_e;

endpackage

// >>> tb/dcmd_ctrl_model.sv
// Controller model driving command pins and array read data.
// Assumes the bench calls issue() and the device samples on ck_i.
`timescale 1ns/1ps
`default_nettype none

module dcmd_ctrl_model (
    // Link clock
    input wire logic ck_i,
    // Command pins
    output logic cke_o,
    output logic cs_n_o,
    output logic ras_n_o,
    output logic cas_n_o,
    output logic we_n_o,
    output logic [2:0] ba_o,
    output logic [15:0] addr_o,
    // Array data behind plain reads
    output logic [15:0] arr_o
);
    logic pend = 1'b0; // Command waiting for next edge
    logic q_cke = 1'b1;
    logic [3:0] q_cmd = 4'hf; // Chip select, row, column, write strobes
    logic [2:0] q_ba = 3'h0;
    logic [15:0] q_addr = 16'h0000, q_arr = 16'h0000;

    // Known levels from time zero
    initial {cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o, ba_o, addr_o, arr_o} = '1;

    // One command per edge, else deselect with lines moving every cycle
    always @(posedge ck_i)
    begin
        cke_o <= q_cke;
        arr_o <= q_arr;
        if (pend)
        begin
            {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= q_cmd;
            ba_o <= q_ba;
            addr_o <= q_addr;
            pend <= 1'b0;
        end
        else
        begin
            cs_n_o <= 1'b1;
            {ras_n_o, cas_n_o, we_n_o, ba_o, addr_o} <= ~{ras_n_o, cas_n_o, we_n_o, ba_o, addr_o};
        end
    end

    // Queue one command; the bench keeps the clock lock, bank idle and mode rules
    task automatic issue(input logic k, input logic [3:0] c, input logic [2:0] b,
                         input logic [15:0] a, input logic [15:0] d);
        @(negedge ck_i);
        {q_cke, q_cmd, q_ba, q_addr, q_arr} = {k, c, b, a, d};
        pend = 1'b1;
        @(posedge ck_i);
    endtask
endmodule

`default_nettype wire

// >>> tb/dcmd_top_assertions.sv
// Port checker for the command decoder, both clock domains.
// Assumes it is bound onto dcmd_top and sees its ports only.
`timescale 1ns/1ps
`default_nettype none

module dcmd_top_assertions
    import dcmd_pkg::*;
(
    // Clocks and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic ck_i,
    // Command pins
    input wire logic cke_i,
    input wire logic cs_n_i,
    input wire logic ras_n_i,
    input wire logic cas_n_i,
    input wire logic we_n_i,
    // Data pins
    input wire logic [15:0] dq_o,
    input wire logic dq_oe_n_o,
    // Command report and status
    input wire logic cmd_valid_o,
    input wire dcmd_kind_e cmd_kind_o,
    input wire logic [2:0] cmd_bank_o,
    input wire logic [15:0] cmd_addr_o,
    input wire logic cmd_ap_o,
    input wire logic mpr_en_o
);
    // Read command taken at a link edge
    sequence s_rd;
        cke_i && $past(cke_i) && !cs_n_i && ras_n_i && !cas_n_i && we_n_i;
    endsequence
    // Chopped and full bursts, then release
    sequence s_bc4;
        !dq_oe_n_o [*4] ##1 dq_oe_n_o;
    endsequence
    sequence s_bl8;
        !dq_oe_n_o [*8] ##1 dq_oe_n_o;
    endsequence

    a_read_latency: assert property (@(posedge ck_i) disable iff (sys_rst_i)
        s_rd |=> dq_oe_n_o [*5] ##[1:3] !dq_oe_n_o) else $error("read data late");
    a_burst_len: assert property (@(posedge ck_i) disable iff (sys_rst_i)
        $fell(dq_oe_n_o) |-> s_bc4 or s_bl8) else $error("burst length wrong");
    a_idle_quiet: assert property (@(posedge ck_i) disable iff (sys_rst_i)
        dq_oe_n_o |-> dq_o == 16'h0000) else $error("data pins busy when idle");
    a_pattern_wide: assert property (@(posedge ck_i) disable iff (sys_rst_i)
        !dq_oe_n_o && mpr_en_o |-> dq_o inside {16'h0000, 16'hffff})
        else $error("pattern bit not replicated");
    a_valid_pulse: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cmd_valid_o |=> !cmd_valid_o) else $error("report pulse too long");
    a_fields_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !cmd_valid_o |-> $stable({cmd_kind_o, cmd_bank_o, cmd_addr_o, cmd_ap_o}))
        else $error("report fields moved");
    a_ap_follow: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cmd_valid_o && !mpr_en_o && cmd_kind_o inside {DCMD_RD, DCMD_WR}
        |-> cmd_ap_o == cmd_addr_o[10]) else $error("precharge flag wrong");
    a_ap_pattern: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cmd_valid_o && mpr_en_o && cmd_kind_o == DCMD_RD |-> !cmd_ap_o)
        else $error("precharge in pattern mode");
    a_prea_bit: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cmd_valid_o && cmd_kind_o inside {DCMD_PRE, DCMD_PREA}
        |-> cmd_addr_o[10] == (cmd_kind_o == DCMD_PREA)) else $error("precharge kind wrong");
    a_zq_kind: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        cmd_valid_o && cmd_kind_o inside {DCMD_ZQCL, DCMD_ZQCS}
        |-> cmd_addr_o[10] == (cmd_kind_o == DCMD_ZQCL)) else $error("calibration kind wrong");
endmodule

bind dcmd_top dcmd_top_assertions u_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ck_i(ck_i), .cke_i(cke_i),
    .cs_n_i(cs_n_i), .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i),
    .dq_o(dq_o), .dq_oe_n_o(dq_oe_n_o), .cmd_valid_o(cmd_valid_o),
    .cmd_kind_o(cmd_kind_o), .cmd_bank_o(cmd_bank_o), .cmd_addr_o(cmd_addr_o),
    .cmd_ap_o(cmd_ap_o), .mpr_en_o(mpr_en_o)
);

`default_nettype wire

// >>> tb/dcmd_top_tb_top.sv
// Bench for the command decoder: command reports, power states, read bursts.
// Assumes the controller model drives every link input of the design except ck_i, which the bench makes.
`timescale 1ns/1ps
`default_nettype none

module dcmd_top_tb_top
    import dcmd_pkg::*;
;
    logic clk_i = 1'b0, ck_i = 1'b0, sys_rst_i = 1'b1;
    logic cke_i, cs_n_i, ras_n_i, cas_n_i, we_n_i, dq_oe_n_o, cmd_valid_o;
    logic cmd_ap_o, cmd_chop_o, mpr_en_o;
    logic [2:0] ba_i, cmd_bank_o, third_mr = 3'h0;
    logic [15:0] addr_i, arr_rdata_i, dq_o, cmd_addr_o, a;
    logic [3:0] c;
    dcmd_kind_e cmd_kind_o;
    dcmd_pwr_e pwr_state_o;
    int error_cnt = 0, n_compared = 0, n_rep = 0;
    logic [31:0] seed = 32'h000125b4; // Random source start
    logic [15:0] beats[$]; // Captured burst beats
    dcmd_kind_e pk[4] = '{DCMD_PDE, DCMD_PDX, DCMD_SRE, DCMD_SRX};
    dcmd_pwr_e pp[4] = '{DCMD_PWR_DOWN, DCMD_PWR_ACTIVE, DCMD_PWR_SELFREF, DCMD_PWR_ACTIVE};

    // System clock 10 ns, link clock 15 ns at an odd phase
    initial forever #5 clk_i = ~clk_i;
    initial
    begin
        #3.3;
        forever #7.5 ck_i = ~ck_i;
    end

    dcmd_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ck_i(ck_i), .cke_i(cke_i),
        .cs_n_i(cs_n_i), .ras_n_i(ras_n_i), .cas_n_i(cas_n_i), .we_n_i(we_n_i),
        .ba_i(ba_i), .addr_i(addr_i), .arr_rdata_i(arr_rdata_i), .dq_o(dq_o),
        .dq_oe_n_o(dq_oe_n_o), .cmd_valid_o(cmd_valid_o), .cmd_kind_o(cmd_kind_o),
        .cmd_bank_o(cmd_bank_o), .cmd_addr_o(cmd_addr_o), .cmd_ap_o(cmd_ap_o),
        .cmd_chop_o(cmd_chop_o), .mpr_en_o(mpr_en_o), .pwr_state_o(pwr_state_o));

    dcmd_ctrl_model u_ctrl (.ck_i(ck_i), .cke_o(cke_i), .cs_n_o(cs_n_i), .ras_n_o(ras_n_i),
        .cas_n_o(cas_n_i), .we_n_o(we_n_i), .ba_o(ba_i), .addr_o(addr_i), .arr_o(arr_rdata_i));

    // Count reports and collect driven beats
    always @(posedge clk_i)
        if (cmd_valid_o === 1'b1) n_rep <= n_rep + 1;
    always @(posedge ck_i)
        if (dq_oe_n_o === 1'b0) beats.push_back(dq_o);

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    // Expected kind from the strobes and bit 10
    function automatic dcmd_kind_e exp_kind(input logic [3:0] k, input logic a10);
        case (k)
            4'h1: return DCMD_REF;
            4'h2: return a10 ? DCMD_PREA : DCMD_PRE;
            4'h3: return DCMD_ACT;
            4'h4: return DCMD_WR;
            4'h5: return DCMD_RD;
            default: return a10 ? DCMD_ZQCL : DCMD_ZQCS;
        endcase
    endfunction

    // Expected beat n: array word, or pattern bit n on every pin
    function automatic logic [15:0] exp_beat(input logic [2:0] m, input int n,
                                             input logic [15:0] d);
        logic [7:0] pat;
        pat = (m[1:0] == 2'h0) ? 8'haa : 8'h00;
        if (!m[2]) return d;
        return {16{pat[n]}};
    endfunction

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Issue a command, wait a bounded time for its report, compare fields
    task automatic cmd(input logic k, input logic [3:0] cc, input logic [2:0] b,
                       input logic [15:0] ad, input dcmd_kind_e ek);
        int r0;
        r0 = n_rep;
        u_ctrl.issue(k, cc, b, ad, ad);
        for (int w = 0; w < 20 && n_rep == r0; w++) @(posedge clk_i);
        chk({12'h000, cmd_kind_o}, {12'h000, ek});
        if (ek < DCMD_SRE) chk({cmd_bank_o, cmd_addr_o[12:0]}, {b, ad[12:0]});
        repeat (16) @(posedge ck_i); // Lets a full burst drain before the next command
    endtask

    // Issue a read and compare the whole burst
    task automatic rd(input logic [2:0] b, input logic [15:0] ad, input int n, input int f);
        logic [15:0] d;
        d = seed[15:0];
        seed = lfsr(seed);
        beats = {};
        u_ctrl.issue(1'b1, 4'h5, b, ad, d);
        repeat (24) @(posedge ck_i);
        chk(16'(beats.size()), 16'(n));
        foreach (beats[i]) chk(beats[i], exp_beat(third_mr, f + i, d));
        chk({14'h0000, cmd_chop_o, cmd_ap_o}, {14'h0000, n == 4, ad[10] && !third_mr[2]});
    endtask

    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial
    begin
        #100000;
        error_cnt++;
        report_and_stop();
    end

    initial
    begin
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (6) @(posedge ck_i);
        for (int i = 0; i < 24; i++)
        begin
            c = 4'h1 + 4'(seed[7:0] % 8'h06);
            cmd(1'b1, c, seed[10:8], seed[31:16], exp_kind(c, seed[26]));
            seed = lfsr(seed);
        end
        $display("test command decode done");
        for (int p = 0; p < 4; p++)
        begin
            cmd(p[0], (p == 2) ? 4'h1 : 4'h7, 3'h0, 16'h0000, pk[p]);
            chk({14'h0000, pwr_state_o}, {14'h0000, pp[p]});
        end
        $display("test power states done");
        cmd(1'b1, 4'h0, 3'h0, 16'h0001, DCMD_MRS);
        cmd(1'b1, 4'h2, 3'h0, 16'h0400, DCMD_PREA);
        for (int l = 0; l < 4; l++)
        begin
            third_mr = 3'h4 | 3'(l);
            cmd(1'b1, 4'h0, 3'h3, 16'(third_mr), DCMD_MRS);
            chk({15'h0000, mpr_en_o}, 16'h0001);
            a = seed[31:16] & 16'heff8;
            rd(seed[2:0], a | 16'h1000, 8, 0);
            rd(seed[5:3], a, 4, 0);
            rd(seed[8:6], a | 16'h0004, 4, 4);
            seed = lfsr(seed);
        end
        $display("test pattern reads done");
        third_mr = 3'h0;
        cmd(1'b1, 4'h0, 3'h3, 16'h0003, DCMD_MRS);
        chk({15'h0000, mpr_en_o}, 16'h0000);
        rd(3'h1, 16'h1408, 8, 0);
        rd(3'h2, 16'h0408, 4, 0);
        cmd(1'b1, 4'h0, 3'h0, 16'h0002, DCMD_MRS);
        rd(3'h3, 16'h1010, 4, 0);
        cmd(1'b1, 4'h0, 3'h0, 16'h0000, DCMD_MRS);
        rd(3'h4, 16'h0010, 8, 0);
        $display("test array reads done");
        report_and_stop();
    end
endmodule

`default_nettype wire
